// ===== design/serial_eeprom_config_loader.sv
// Serial EEPROM configuration loader: reads the image over the master SMBus and
// writes doublewords into the device register space.
// Assumes a Wishbone classic master, open-drain SMBus pads and a register file that
// answers cfg_wr_mapped combinationally for the address on cfg_wr.
`timescale 1ns/1ps

module serial_eeprom_config_loader
    import eeprom_loader_pkg::*;
#(
    parameter int         QTR_CYCLES = QTR_CYC,
    parameter logic [7:0] EE_MODES   = 8'hFF
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    // Wishbone classic slave
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [WB_AW-1:0] wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    // Straps and reset requests
    input  wire logic [2:0]       switch_operating_mode,
    input  wire logic [3:0]       eeprom_addr_pins,
    input  wire logic             hot_reset_req,
    // Master SMBus pads
    input  wire logic             scl_i,
    output logic                  scl_o,
    output logic                  scl_oe_n,
    input  wire logic             sda_i,
    output logic                  sda_o,
    output logic                  sda_oe_n,
    // Register write port
    output logic                  cfg_wr_en,
    output cfg_wr_t               cfg_wr,
    input  wire logic             cfg_wr_mapped,
    // Device state
    output logic                  halt_after_reset,
    output logic                  load_busy
);

    typedef enum logic [1:0] {L_IDLE, L_START, L_STOP, L_BYTE} lop_t;
    typedef enum logic [2:0] {T_IDLE, T_HDR, T_RD, T_STOP, T_FIN, T_WAIT} seq_t;
    typedef enum logic [2:0] {P_A0, P_A1, P_TY, P_C0, P_C1, P_DAT} prs_t;

    ////////////////////////////////////////////////////////////////////////////////
    // Pad and strap synchronisers
    logic [8:0] sync1_ff;
    logic [8:0] sync2_ff;
    logic       scl_p_ff;
    logic       sda_p_ff;
    logic [1:0] boot_ff;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sync1_ff <= 9'h1FF;
            sync2_ff <= 9'h1FF;
            scl_p_ff <= 1'h1;
            sda_p_ff <= 1'h1;
        end else begin
            sync1_ff <= {eeprom_addr_pins, switch_operating_mode, sda_i, scl_i};
            sync2_ff <= sync1_ff;
            scl_p_ff <= sync2_ff[0];
            sda_p_ff <= sync2_ff[1];
        end
    end

    wire       scl_s  = sync2_ff[0];
    wire       sda_s  = sync2_ff[1];
    wire [2:0] mode_s = sync2_ff[4:2];
    wire [3:0] pins_s = sync2_ff[8:5];

    wire bus_start = scl_s & scl_p_ff & sda_p_ff & ~sda_s;
    wire bus_stop  = scl_s & scl_p_ff & ~sda_p_ff & sda_s;

    // The reset-time load looks at the straps only once the synchronisers hold settled values; hot_reset_req is not held back
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            boot_ff <= 2'h0;
        end else if (boot_ff != 2'h3) begin
            boot_ff <= boot_ff + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Quarter-bit divider
    logic [QDIV_W-1:0] qdiv_ff;
    wire               tick = (qdiv_ff == QDIV_W'(QTR_CYCLES - 1));

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            qdiv_ff <= '0;
        end else begin
            qdiv_ff <= tick ? '0 : qdiv_ff + QDIV_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer and parser state
    seq_t        seq_ff;
    prs_t        prs_ff;
    logic [2:0]  hdr_ff;
    logic [4:0]  arb_cnt_ff;
    logic [15:0] ee_addr_ff;
    logic [15:0] dwa_ff;
    logic [15:0] cnt_ff;
    logic [31:0] dat_ff;
    logic [1:0]  bidx_ff;
    logic [7:0]  sum_ff;
    logic        end_rd_ff;
    logic        wr_pend_ff;
    logic        ctrl_ign_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Bit engine: START, STOP or nine-bit byte, four quarters per bit
    lop_t       lop_ff;
    logic [1:0] q_ff;
    logic [3:0] bit_ff;
    logic [7:0] tx_ff;
    logic [7:0] rx_ff;
    logic       rd_ff;
    logic       scl_rel_ff;
    logic       sda_rel_ff;

    wire       step    = (lop_ff == L_IDLE);
    wire       ack_slot = (bit_ff == ACK_BIT);
    wire       txbit   = rd_ff ? (ack_slot ? end_rd_ff : 1'h1) : (ack_slot | tx_ff[7]);
    wire       scl_want = (q_ff == 2'h1) | (q_ff == 2'h2) | (lop_ff == L_STOP & q_ff == 2'h3);
    wire       sda_want = (lop_ff == L_START) ? (q_ff < 2'h2) :
                          (lop_ff == L_STOP)  ? (q_ff >= 2'h2) : txbit;
    // Clock stretching: a slave holding SCL low freezes the high quarter
    wire       adv      = tick & ~(q_ff == 2'h1 & ~scl_s);
    wire       sample   = adv & (lop_ff == L_BYTE) & (q_ff == 2'h2);
    wire [7:0] rxb      = {rx_ff[6:0], sda_s};

    wire arb_ev  = sample & ~rd_ff & ~ack_slot & txbit & ~sda_s;
    wire nak_ev  = sample & ~rd_ff & ack_slot & sda_s;
    wire prot_ev = (lop_ff == L_BYTE) & (bus_start | bus_stop);
    wire byte_ev = sample & rd_ff & (bit_ff == 4'h7) & (seq_ff == T_RD);

    // Issue selection
    wire [6:0] dev_addr  = {EE_DEV_HI, pins_s};
    wire       hdr_start = (hdr_ff == 3'h0) | (hdr_ff == 3'h4);
    wire [7:0] hdr_tx    = (hdr_ff == 3'h1) ? {dev_addr, 1'h0} :
                           (hdr_ff == 3'h2) ? ee_addr_ff[15:8] :
                           (hdr_ff == 3'h3) ? ee_addr_ff[7:0]  : {dev_addr, 1'h1};
    wire lop_t issue_op  = !step ? L_IDLE :
                           (seq_ff == T_HDR) ? (hdr_start ? L_START : L_BYTE) :
                           (seq_ff == T_RD & ~end_rd_ff) ? L_BYTE :
                           (seq_ff == T_STOP) ? L_STOP : L_IDLE;

    wire start_ev  = ((boot_ff == 2'h2) | hot_reset_req) & EE_MODES[mode_s]
                     & (seq_ff == T_IDLE);
    wire link_kill = arb_ev | prot_ev;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            lop_ff     <= L_IDLE;
            q_ff       <= 2'h0;
            bit_ff     <= 4'h0;
            tx_ff      <= 8'h00;
            rx_ff      <= 8'h00;
            rd_ff      <= 1'h0;
            scl_rel_ff <= 1'h1;
            sda_rel_ff <= 1'h1;
        end else if (link_kill | start_ev) begin
            lop_ff     <= L_IDLE;
            scl_rel_ff <= 1'h1;
            sda_rel_ff <= 1'h1;
        end else if (step) begin
            if (issue_op != L_IDLE) begin
                lop_ff <= issue_op;
                q_ff   <= 2'h0;
                bit_ff <= 4'h0;
                tx_ff  <= hdr_tx;
                rd_ff  <= (seq_ff == T_RD);
            end
        end else begin
            scl_rel_ff <= scl_want;
            sda_rel_ff <= sda_want;
            if (adv) begin
                q_ff <= q_ff + 2'h1;
                if (sample & ~ack_slot) begin
                    rx_ff <= rxb;
                end
                if (q_ff == 2'h3) begin
                    if (lop_ff == L_BYTE & ~ack_slot) begin
                        bit_ff <= bit_ff + 4'h1;
                        tx_ff  <= {tx_ff[6:0], 1'h0};
                    end else begin
                        lop_ff <= L_IDLE;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer: address header, streaming reads, closing STOP
    wire [4:0] arb_next = arb_cnt_ff + 5'h01;
    wire       set_arb  = arb_ev & (arb_next == ARB_LOSS_MAX);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            seq_ff     <= T_IDLE;
            hdr_ff     <= 3'h0;
            arb_cnt_ff <= 5'h00;
        end else if (start_ev) begin
            seq_ff     <= T_HDR;
            hdr_ff     <= 3'h0;
            arb_cnt_ff <= 5'h00;
        end else if (prot_ev) begin
            seq_ff <= T_IDLE;
        end else if (arb_ev) begin
            // Lost bus: wait for the winner's STOP, then resend the header; the 16th loss with no byte read in between ends the load
            arb_cnt_ff <= arb_next;
            seq_ff     <= set_arb ? T_IDLE : T_WAIT;
        end else if (nak_ev) begin
            seq_ff <= T_STOP;
        end else begin
            if (byte_ev) begin
                arb_cnt_ff <= 5'h00;
            end
            unique case (seq_ff)
                T_IDLE: begin
                end
                T_HDR: begin
                    if (step) begin
                        hdr_ff <= hdr_ff + 3'h1;
                        if (hdr_ff == 3'h5) begin
                            seq_ff <= T_RD;
                        end
                    end
                end
                T_RD: begin
                    if (step & end_rd_ff) begin
                        seq_ff <= T_STOP;
                    end
                end
                T_STOP: begin
                    if (step) begin
                        seq_ff <= T_FIN;
                    end
                end
                T_FIN: begin
                    if (step) begin
                        seq_ff <= T_IDLE;
                    end
                end
                T_WAIT: begin
                    if (bus_stop) begin
                        seq_ff <= T_HDR;
                        hdr_ff <= 3'h0;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Block parser, fed one byte per read
    wire [1:0] ty        = rxb[1:0];
    wire       is_ty     = (prs_ff == P_TY);
    wire       done_byte = is_ty & (ty == TY_DONE);
    wire [7:0] sum_nxt   = sum_ff + rxb;
    // The image builder's complemented sum makes a clean image total 0xFF
    wire       bad_sum   = done_byte & (sum_nxt != SUM_GOOD) & ~ctrl_ign_ff;
    wire       roll      = (ee_addr_ff == EE_LAST) & ~done_byte;
    wire       set_csum  = byte_ev & ((is_ty & ty == TY_BAD) | bad_sum | roll);
    wire       last_word = (prs_ff == P_DAT) & (bidx_ff == LAST_DATA);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            prs_ff     <= P_A0;
            ee_addr_ff <= 16'h0000;
            dwa_ff     <= 16'h0000;
            cnt_ff     <= 16'h0000;
            dat_ff     <= 32'h0000_0000;
            bidx_ff    <= 2'h0;
            sum_ff     <= 8'h00;
            end_rd_ff  <= 1'h0;
            wr_pend_ff <= 1'h0;
            cfg_wr     <= '0;
        end else if (start_ev) begin
            prs_ff     <= P_A0;
            ee_addr_ff <= 16'h0000;
            sum_ff     <= 8'h00;
            end_rd_ff  <= 1'h0;
            wr_pend_ff <= 1'h0;
        end else begin
            wr_pend_ff <= byte_ev & last_word;
            if (byte_ev) begin
                ee_addr_ff <= ee_addr_ff + 16'h0001;
                sum_ff     <= sum_nxt;
                if (set_csum | done_byte) begin
                    end_rd_ff <= 1'h1;
                end
                unique case (prs_ff)
                    P_A0: begin
                        dwa_ff[7:0] <= rxb;
                        prs_ff      <= P_A1;
                    end
                    P_A1: begin
                        dwa_ff[15:8] <= rxb;
                        prs_ff       <= P_TY;
                    end
                    P_TY: begin
                        bidx_ff <= 2'h0;
                        cnt_ff  <= 16'h0001;
                        prs_ff  <= (ty == TY_SEQ) ? P_C0 : (ty == TY_SINGLE) ? P_DAT : P_A0;
                    end
                    P_C0: begin
                        cnt_ff[7:0] <= rxb;
                        prs_ff      <= P_C1;
                    end
                    P_C1: begin
                        cnt_ff[15:8] <= rxb;
                        // A zero count carries no data words
                        prs_ff <= ({rxb, cnt_ff[7:0]} == 16'h0000) ? P_A0 : P_DAT;
                    end
                    P_DAT: begin
                        dat_ff  <= {rxb, dat_ff[31:8]};
                        bidx_ff <= bidx_ff + 2'h1;
                        if (bidx_ff == LAST_DATA) begin
                            cfg_wr.addr <= {SYS_ADDR_PAD, dwa_ff, 2'h0};
                            cfg_wr.data <= {rxb, dat_ff[31:8]};
                            dwa_ff      <= dwa_ff + 16'h0001;
                            cnt_ff      <= cnt_ff - 16'h0001;
                            if (cnt_ff == 16'h0001) begin
                                prs_ff <= P_A0;
                            end
                        end
                    end
                    default: begin
                        prs_ff <= P_A0;
                    end
                endcase
            end
        end
    end

    // Unmapped targets never reach the register file
    assign cfg_wr_en = wr_pend_ff & cfg_wr_mapped;

    ////////////////////////////////////////////////////////////////////////////////
    // Status, control and switch control registers
    ld_stat_t stat_ff;
    ld_stat_t stat_set;
    logic     halt_ff;

    assign stat_set.unmap = wr_pend_ff & ~cfg_wr_mapped;
    assign stat_set.csum  = set_csum;
    assign stat_set.nack  = nak_ev & (seq_ff != T_IDLE);
    assign stat_set.arb   = set_arb;
    assign stat_set.prot  = prot_ev & (seq_ff != T_IDLE);
    assign stat_set.done  = set_arb | stat_set.prot
                            | (seq_ff == T_FIN & step);
    wire   set_halt = set_arb | stat_set.prot | stat_set.nack | set_csum;

    logic [31:0] wb_dat_ff;
    logic        wb_ack_ff;
    wire         wb_hit  = wb_cyc_i & wb_stb_i & ~wb_ack_ff;
    wire         wb_wr   = wb_hit & wb_we_i & wb_sel_i[0];
    wire         wr_stat = wb_wr & (wb_adr_i == OFF_STATUS);
    wire         wr_ctrl = wb_wr & (wb_adr_i == OFF_CTRL);
    wire         wr_sw   = wb_wr & (wb_adr_i == OFF_SWITCH_CONTROL_REG);
    wire ld_stat_t w1c   = wr_stat ? ld_stat_t'(wb_dat_i[5:0]) : '0;
    wire [31:0]  rd_data = (wb_adr_i == OFF_STATUS) ? {26'h0, stat_ff} :
                           (wb_adr_i == OFF_CTRL)   ? {31'h0, ctrl_ign_ff} :
                           (wb_adr_i == OFF_SWITCH_CONTROL_REG)  ? {31'h0, halt_ff} : 32'h0000_0000;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            stat_ff     <= '0;
            ctrl_ign_ff <= CTRL_RST;
            halt_ff     <= HALT_RST;
            wb_ack_ff   <= 1'h0;
            wb_dat_ff   <= 32'h0000_0000;
        end else begin
            // A hardware set in the same cycle as a software clear wins
            stat_ff <= (stat_ff & ~w1c) | stat_set;
            if (start_ev) begin
                stat_ff.done <= 1'h0;
            end
            if (wr_ctrl) begin
                ctrl_ign_ff <= wb_dat_i[CT_IGNSUM];
            end
            halt_ff   <= (wr_sw ? wb_dat_i[SW_HALT] : halt_ff) | set_halt;
            wb_ack_ff <= wb_hit;
            if (wb_hit) begin
                wb_dat_ff <= rd_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign wb_ack_o         = wb_ack_ff;
    assign wb_dat_o         = wb_dat_ff;
    assign scl_o            = 1'h0;
    assign sda_o            = 1'h0;
    assign scl_oe_n         = scl_rel_ff;
    assign sda_oe_n         = sda_rel_ff;
    assign halt_after_reset = halt_ff;
    assign load_busy        = (seq_ff != T_IDLE);

endmodule

// ===== shared/eeprom_loader_pkg.sv
// Constants, register map and carriers of the serial EEPROM configuration loader.
// Assumes a 100 MHz core clock and one EEPROM on the master SMBus.
package eeprom_loader_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus timing: the SMBus bit is cut into four quarters
    localparam int CLK_MHZ = 100;
    localparam int QTR_NS  = 2500;
    localparam int QTR_CYC = (QTR_NS * CLK_MHZ + 999) / 1000;
    localparam int QDIV_W  = 12;

    ////////////////////////////////////////////////////////////////////////////////
    // Image stream
    localparam logic [7:0]  SUM_GOOD     = 8'hFF;
    localparam logic [15:0] EE_LAST      = 16'hFFFF;
    localparam logic [2:0]  EE_DEV_HI    = 3'h5;
    localparam logic [3:0]  ACK_BIT      = 4'h8;
    localparam logic [4:0]  ARB_LOSS_MAX = 5'h10;
    localparam logic [1:0]  LAST_DATA    = 2'h3;
    localparam logic [1:0]  TY_SINGLE    = 2'h0;
    localparam logic [1:0]  TY_SEQ       = 2'h1;
    localparam logic [1:0]  TY_BAD       = 2'h2;
    localparam logic [1:0]  TY_DONE      = 2'h3;
    localparam logic [13:0] SYS_ADDR_PAD = 14'h0000;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam int         WB_AW      = 8;
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_CTRL   = 8'h04;
    localparam logic [7:0] OFF_SWITCH_CONTROL_REG  = 8'h08;
    localparam int         CT_IGNSUM  = 0;
    localparam int         SW_HALT    = 0;
    localparam logic       CTRL_RST   = 1'h0;
    localparam logic       HALT_RST   = 1'h0;

    // Status layout, bit 0 first: done, unmapped, checksum, nack, arbitration, protocol
    typedef struct packed {
        logic prot;
        logic arb;
        logic nack;
        logic csum;
        logic unmap;
        logic done;
    } ld_stat_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
    } cfg_wr_t;

endpackage

// ===== tb/eeprom_model.sv
// Behavioural serial EEPROM on the master SMBus.
// Assumes a pulled-up bus resolved by the bench; it never stretches the clock.
`timescale 1ns/1ps
module eeprom_model (
    // Bus lines and fault control
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic nak,
    output logic      sda_low
);
    logic [7:0]  mem [0:255];
    logic [7:0]  sh = 8'h00;
    logic [15:0] a = 16'h0000;
    logic        rd = 1'b0;
    int          bits = 0, nb = 0;
    initial begin
        sda_low = 1'b0;
        foreach (mem[i]) mem[i] = 8'hFF;
    end
    // Only a START reframes; a STOP needs no action
    always @(negedge sda) if (scl) begin
        bits = 0;
        nb = 0;
        rd = 1'b0;
    end
    always @(posedge scl) begin
        sh = {sh[6:0], sda};
        bits++;
    end
    // Data changes only while the clock is low
    always @(negedge scl) begin
        if (bits == 8) begin
            if (nb == 0) rd = sh[0];
            if (!rd && nb == 1) a[15:8] = sh;
            if (!rd && nb == 2) a[7:0] = sh;
            // Only our own device address is acknowledged
            sda_low = !nak && !(rd && nb > 0) && !(nb == 0 && sh[7:1] != 7'h53);
        end else begin
            if (bits == 9) begin
                bits = 0;
                if (rd && nb > 0 && sh[0]) rd = 1'b0;
                nb++;
                if (rd && nb > 1) a++;
            end
            sda_low = rd && nb > 0 && bits < 8 && !mem[a[7:0]][7 - bits];
        end
    end
endmodule

// ===== tb/serial_eeprom_config_loader_assertions.sv
// Port-level checks of the configuration loader.
// Assumes one clock domain with an asynchronous active-low reset.
`timescale 1ns/1ps
module serial_eeprom_config_loader_assertions
    import eeprom_loader_pkg::*;
(
    // Clock, reset, register bus and loader state
    input wire logic    clk_sys, resetn, wb_cyc_i, wb_stb_i, wb_ack_o,
    input wire logic    scl_oe_n, sda_oe_n, cfg_wr_en, cfg_wr_mapped,
    input wire logic    halt_after_reset, load_busy,
    input wire cfg_wr_t cfg_wr
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence idle_s; !load_busy [*3]; endsequence
    AST_ACK: assert property (req_s |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single pulse");
    AST_MAPPED: assert property (cfg_wr_en |-> cfg_wr_mapped)
        else $error("write to unmapped address");
    AST_ALIGN: assert property (cfg_wr_en |-> cfg_wr.addr[1:0] == 2'h0
        && cfg_wr.addr[31:18] == 14'h0) else $error("system address malformed");
    AST_WRITTEN: assert property ($changed(cfg_wr) && cfg_wr_mapped |-> cfg_wr_en)
        else $error("mapped word not written");
    AST_IN_LOAD: assert property (cfg_wr_en |-> load_busy)
        else $error("register write outside a load");
    AST_SPACING: assert property (cfg_wr_en |=> !cfg_wr_en [*8])
        else $error("write pulses too close");
    AST_HOLD: assert property (cfg_wr_en |=> $stable(cfg_wr) [*8])
        else $error("write word changed early");
    AST_HALT: assert property ($rose(halt_after_reset) |-> $past(load_busy) || $past(wb_stb_i))
        else $error("halt set without a load");
    AST_FREE: assert property (idle_s |-> scl_oe_n && sda_oe_n)
        else $error("bus held while idle");
endmodule
bind serial_eeprom_config_loader serial_eeprom_config_loader_assertions chk_i (
    .clk_sys, .resetn, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .scl_oe_n, .sda_oe_n,
    .cfg_wr_en, .cfg_wr_mapped, .halt_after_reset, .load_busy, .cfg_wr);

// ===== tb/test_serial_eeprom_config_loader.sv
// Bench for the configuration loader: bus tasks and one EEPROM image.
// Assumes the behavioural EEPROM model on a pulled-up bus.
`timescale 1ns/1ps
module test_serial_eeprom_config_loader;
    import eeprom_loader_pkg::*;
    logic        clk_sys = 1'b0, resetn = 1'b0, cyc = 1'b0, we = 1'b0, hot = 1'b0;
    logic        nak = 1'b0, ack, scl_o, scl_oe_n, sda_o, sda_oe_n, cfg_wr_en, halt, busy;
    logic        sda_low, glitch = 1'b0;
    logic [2:0]  mode = 3'h0;
    logic [7:0]  adr = 8'h00, sum = 8'h00;
    logic [31:0] dat = 32'h0, rdat;
    cfg_wr_t     cfg_wr, log [$];
    int          fails = 0, checks = 0, ni = 0;
    wire         scl = scl_oe_n | scl_o;
    wire         sda = (sda_oe_n | sda_o) & !sda_low & !glitch;
    localparam logic [7:0] IMG [20] = '{8'h10, 8'h00, 8'h00, 8'h44, 8'h33, 8'h22, 8'h11,
        8'h20, 8'h00, 8'h01, 8'h02, 8'h00, 8'h01, 8'h00, 8'hFE, 8'hCA, 8'h02, 8'h00,
        8'hFE, 8'hCA};
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (cfg_wr_en === 1'b1) log.push_back(cfg_wr);
    serial_eeprom_config_loader #(.QTR_CYCLES(4), .EE_MODES(8'hFE)) dut (
        .clk_sys, .resetn, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .switch_operating_mode(mode), .eeprom_addr_pins(4'h3), .hot_reset_req(hot),
        .scl_i(scl), .scl_o, .scl_oe_n, .sda_i(sda), .sda_o, .sda_oe_n, .cfg_wr_en,
        .cfg_wr, .cfg_wr_mapped(cfg_wr.addr != 32'h84), .halt_after_reset(halt),
        .load_busy(busy));
    eeprom_model eep (.scl, .sda, .nak, .sda_low);
    task automatic close_out;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_sys);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk_sys); while (ack !== 1'b1 && ++n < 50);
        cyc <= 1'b0;
        if (ack !== 1'b1) begin
            fails++;
            close_out;
        end
    endtask
    // Status is cleared first so every load is judged on its own flags
    task automatic run(input logic ig, nk, gl, input logic [31:0] st);
        int n = 0;
        wb(1'b1, OFF_STATUS, 32'h3F);
        wb(1'b1, OFF_SWITCH_CONTROL_REG, 32'h0);
        wb(1'b1, OFF_CTRL, {31'h0, ig});
        nak <= nk;
        hot <= 1'b1;
        @(posedge clk_sys);
        hot <= 1'b0;
        do @(posedge clk_sys); while (busy !== 1'b1 && ++n < 50);
        // A false START while the clock is high inside the address byte
        if (gl) begin
            repeat (40) @(posedge clk_sys);
            do @(posedge clk_sys); while (!(scl === 1'b1 && sda === 1'b1) && ++n < 400);
            glitch <= 1'b1;
            repeat (2) @(posedge clk_sys);
            glitch <= 1'b0;
        end
        do @(posedge clk_sys); while (busy !== 1'b0 && ++n < 40000);
        if (busy !== 1'b0) begin
            fails++;
            close_out;
        end
        wb(1'b0, OFF_STATUS, 32'h0);
        chk("status", rdat, st);
        wb(1'b0, OFF_SWITCH_CONTROL_REG, 32'h0);
        chk("halt", rdat, {31'h0, |st[5:2]});
        chk("halt pin", halt, {31'h0, |st[5:2]});
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (20) @(posedge clk_sys);
        chk("idle", busy, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wb(1'b0, 8'(4 * i), 32'h0);
            chk("reset value", rdat, 32'h0);
        end
        foreach (IMG[i]) begin
            eep.mem[ni++] = IMG[i];
            sum += IMG[i];
        end
        eep.mem[ni] = ~(sum + 8'h03);
        eep.mem[ni + 2] = 8'h03;
        eep.mem[ni + 1] = 8'h00;
        mode <= 3'h1;
        run(1'b0, 1'b0, 1'b0, 32'h3);
        chk("writes", log.size(), 32'h2);
        chk("addr0", log[0].addr, 32'h40);
        chk("data0", log[0].data, 32'h11223344);
        chk("addr1", log[1].addr, 32'h80);
        chk("data1", log[1].data, 32'hCAFE0001);
        eep.mem[3] = 8'h45;
        run(1'b1, 1'b0, 1'b0, 32'h3);
        run(1'b0, 1'b0, 1'b0, 32'h7);
        eep.mem[2] = 8'h02;
        run(1'b0, 1'b0, 1'b0, 32'h5);
        eep.mem[2] = 8'h00;
        run(1'b0, 1'b0, 1'b1, 32'h21);
        run(1'b0, 1'b1, 1'b0, 32'h9);
        close_out;
    end
endmodule
